/* File: core/adc_range_alarm_registers.sv */
// Behaviour
// - range register bits 6:4 hold even channel code, pairs at 10h-13h
// - range register bits 2:0 hold odd channel code
// - codes 1,2,3,5,6 valid; 0,4,7 reserved and not to be written
// - converted channel's programmed range is applied in any scan mode
// - active flag follows the alarm condition
// - tripped flag sets with active flag, holds until read
// - temp flags: tripped low 7, high 6, active low 5, high 4
// - 21h-24h hold tripped/active for channels 0-3 and 4-7
// - alarm raises the pin; host answers by reading flags
// - bit 0 of 7Fh selects the page, persisting until changed
// - page 0 selected after reset
// - upper byte margin 7:4, limit 11:8; lower byte limit 7:0
// - page 1 00h-03h hold temperature low then high limits
// - margin 0 means none, k means plus or minus k lsb
// - pin acts as alarm output when pin function bit is zero
// - page 1 04h-23h hold four limit bytes per channel
`timescale 1ns/1ps
`default_nettype none
module adc_range_alarm_registers (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic conv_valid,
    input wire logic conv_temp,
    input wire logic [2:0] conv_chan,
    input wire logic [11:0] conv_data,
    output logic [2:0] conv_range,
    input wire logic pd_pin_in,
    output logic alarm_or_powerdown_pin,
    output logic alarm_or_powerdown_oe,
    output logic powerdown_req
);
    localparam int nsrc = alarm_regs_pkg::chans + 1;

    logic [7:0] range_r [4];
    logic [7:0] range_nxt [4];
    // page 1 is nothing but limit bytes, four per alarm source
    logic [7:0] limit_r [alarm_regs_pkg::limit_regs];
    logic [7:0] limit_nxt [alarm_regs_pkg::limit_regs];
    logic page_r;
    logic page_nxt;
    logic [7:0] aux_r;
    logic [7:0] aux_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] crange_r;
    logic [2:0] crange_nxt;
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;
    logic pd_r;
    logic pd_nxt;
    logic [nsrc-1:0] trip_lo_r;
    logic [nsrc-1:0] trip_lo_nxt;
    logic [nsrc-1:0] trip_hi_r;
    logic [nsrc-1:0] trip_hi_nxt;
    logic [nsrc-1:0] act_lo;
    logic [nsrc-1:0] act_hi;
    logic [nsrc-1:0] clr_lo;
    logic [nsrc-1:0] clr_hi;
    logic pd_sync;

    // bytes come in as arguments so the connection follows every write
    function automatic logic [15:0] limit_word(input logic [7:0] upper,
                                               input logic [7:0] lower);
        limit_word = {upper, lower};
    endfunction

    // gather two flag bits per channel, lowest channel at the top
    function automatic logic [7:0] pack4(input logic [3:0] lo,
                                         input logic [3:0] hi);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 4; i++) begin
            v[7-2*i] = lo[i];
            v[6-2*i] = hi[i];
        end
        pack4 = v;
    endfunction

    // ------------------------------------------------------------
    // alarm comparators: index 8 is the temperature sensor
    // ------------------------------------------------------------
    for (genvar g = 0; g < nsrc; g++) begin : g_cmp
        localparam int base = (g == alarm_regs_pkg::chans) ? 0 : 4 + 4*g;
        logic hit;
        assign hit = conv_valid && ((g == alarm_regs_pkg::chans)
            ? conv_temp : (!conv_temp && conv_chan == 3'(g)));
        // every comparator sees each result; hit picks out its own
        // live flag tracks condition
        alarm_compare u_cmp (
            .mclk(mclk),
            .rst_n(rst_n),
            .sample_valid(hit),
            .sample(conv_data),
            .low_limit(limit_word(limit_r[base], limit_r[base + 1])),
            .high_limit(limit_word(limit_r[base + 2], limit_r[base + 3])),
            .low_active(act_lo[g]),
            .high_active(act_hi[g])
        );
    end

    sync2 u_pd_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(pd_pin_in),
        .q(pd_sync)
    );

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // limit storage must hold four bytes for every alarm source
    if (alarm_regs_pkg::limit_regs != 4 * nsrc) begin : g_bad_limits
        $error("limit storage does not match alarm sources");
    end

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            range_nxt[i] = range_r[i];
        end
        for (int i = 0; i < alarm_regs_pkg::limit_regs; i++) begin
            limit_nxt[i] = limit_r[i];
        end
        page_nxt = page_r;
        aux_nxt = aux_r;
        rdata_nxt = rdata_r;
        clr_lo = '0;
        clr_hi = '0;
        if (reg_wr) begin
            if (reg_addr == alarm_regs_pkg::bank_select_addr) begin
                page_nxt = reg_wdata[0];
            end else if (page_r) begin
                if (reg_addr <= alarm_regs_pkg::chan_limit_last_addr) begin
                    limit_nxt[reg_addr[5:0]] = reg_wdata;
                end
            end else if (reg_addr == alarm_regs_pkg::aux_config_addr) begin
                aux_nxt = reg_wdata;
            end else if (reg_addr >= alarm_regs_pkg::range_base_addr &&
                         reg_addr <= alarm_regs_pkg::range_last_addr) begin
                // bits 7 and 3 forced low, host should write zero
                range_nxt[reg_addr[1:0]] = reg_wdata & 8'h77;
            end
        end
        if (reg_rd) begin
            // unmapped reads give zero, never stale data
            rdata_nxt = 8'h00;
            if (reg_addr == alarm_regs_pkg::bank_select_addr) begin
                rdata_nxt = {7'h00, page_r};
            end else if (page_r) begin
                // limit bytes returned whole, upper and lower alike
                if (reg_addr <= alarm_regs_pkg::chan_limit_last_addr) begin
                    rdata_nxt = limit_r[reg_addr[5:0]];
                end
            end else begin
                case (reg_addr)
                    alarm_regs_pkg::aux_config_addr: rdata_nxt = aux_r;
                    alarm_regs_pkg::temp_flags_addr: begin
                        // temp flag layout, low nibble zero
                        rdata_nxt = {trip_lo_r[8], trip_hi_r[8],
                                     act_lo[8], act_hi[8], 4'h0};
                        clr_lo[8] = trip_lo_r[8];
                        clr_hi[8] = trip_hi_r[8];
                    end
                    alarm_regs_pkg::latched_lower_addr: begin
                        rdata_nxt = pack4(trip_lo_r[3:0], trip_hi_r[3:0]);
                        clr_lo[3:0] = trip_lo_r[3:0];
                        clr_hi[3:0] = trip_hi_r[3:0];
                    end
                    alarm_regs_pkg::live_lower_addr:
                        rdata_nxt = pack4(act_lo[3:0], act_hi[3:0]);
                    alarm_regs_pkg::latched_upper_addr: begin
                        rdata_nxt = pack4(trip_lo_r[7:4], trip_hi_r[7:4]);
                        clr_lo[7:4] = trip_lo_r[7:4];
                        clr_hi[7:4] = trip_hi_r[7:4];
                    end
                    alarm_regs_pkg::live_upper_addr:
                        rdata_nxt = pack4(act_lo[7:4], act_hi[7:4]);
                    default: begin
                        if (reg_addr >= alarm_regs_pkg::range_base_addr &&
                            reg_addr <= alarm_regs_pkg::range_last_addr)
                            rdata_nxt = range_r[reg_addr[1:0]];
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                range_r[i] <= alarm_regs_pkg::range_reset;
            end
            for (int i = 0; i < alarm_regs_pkg::limit_regs; i++) begin
                limit_r[i] <= alarm_regs_pkg::limit_reset;
            end
            page_r <= 1'b0;
            aux_r <= alarm_regs_pkg::aux_reset;
            rdata_r <= 8'h00;
        end else begin
            range_r <= range_nxt;
            limit_r <= limit_nxt;
            page_r <= page_nxt;
            aux_r <= aux_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // tripped flags
    // ------------------------------------------------------------
    always_comb begin
        // clear only returned bits, set wins
        trip_lo_nxt = (trip_lo_r & ~clr_lo) | act_lo;
        trip_hi_nxt = (trip_hi_r & ~clr_hi) | act_hi;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trip_lo_r <= '0;
            trip_hi_r <= '0;
        end else begin
            trip_lo_r <= trip_lo_nxt;
            trip_hi_r <= trip_hi_nxt;
        end
    end

    // ------------------------------------------------------------
    // range lookup and pin
    // ------------------------------------------------------------
    always_comb begin
        crange_nxt = crange_r;
        if (conv_valid && !conv_temp) begin
            crange_nxt = conv_chan[0]
                ? range_r[conv_chan[2:1]][alarm_regs_pkg::odd_range_lsb+:3]
                : range_r[conv_chan[2:1]][alarm_regs_pkg::even_range_lsb+:3];
        end
        // pin is alarm output when function bit is zero
        // any tripped alarm raises the pin
        oe_nxt = !aux_r[alarm_regs_pkg::pin_function_bit];
        // a tripped flag holds the pin until the host has read it
        pin_nxt = oe_nxt && ((|trip_lo_r) || (|trip_hi_r));
        // the pin level only counts while the pin is an input
        pd_nxt = !oe_nxt && pd_sync;
    end

    // reset leaves the pin an alarm output, as the aux reset implies
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            crange_r <= alarm_regs_pkg::range_pm10;
            pin_r <= 1'b0;
            oe_r <= 1'b1;
            pd_r <= 1'b0;
        end else begin
            crange_r <= crange_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
            pd_r <= pd_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign conv_range = crange_r;
    assign alarm_or_powerdown_pin = pin_r;
    assign alarm_or_powerdown_oe = oe_r;
    assign powerdown_req = pd_r;
endmodule
`default_nettype wire

/* File: core/alarm_regs_pkg.sv */
package alarm_regs_pkg;
    // ------------------------------------------------------------
    // register offsets, page 0
    // ------------------------------------------------------------
    localparam logic [6:0] aux_config_addr = 7'h06;
    localparam logic [6:0] range_base_addr = 7'h10;
    localparam logic [6:0] range_last_addr = 7'h13;
    localparam logic [6:0] temp_flags_addr = 7'h20;
    localparam logic [6:0] latched_lower_addr = 7'h21;
    localparam logic [6:0] live_lower_addr = 7'h22;
    localparam logic [6:0] latched_upper_addr = 7'h23;
    localparam logic [6:0] live_upper_addr = 7'h24;
    localparam logic [6:0] bank_select_addr = 7'h7f;
    // ------------------------------------------------------------
    // register offsets, page 1
    // ------------------------------------------------------------
    localparam logic [6:0] temp_low_upper_addr = 7'h00;
    localparam logic [6:0] temp_high_lower_addr = 7'h03;
    localparam logic [6:0] chan_limit_base_addr = 7'h04;
    localparam logic [6:0] chan_limit_last_addr = 7'h23;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int even_range_lsb = 4;
    localparam int odd_range_lsb = 0;
    localparam int pin_function_bit = 3;
    localparam logic [7:0] range_reset = 8'h11;
    localparam logic [7:0] limit_reset = 8'h00;
    localparam logic [7:0] aux_reset = 8'h00;
    localparam logic [2:0] range_pm10 = 3'h1;
    localparam int limit_regs = 36;
    localparam int chans = 8;
endpackage

/* File: core/alarm_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module alarm_compare (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [11:0] sample,
    input wire logic [15:0] low_limit,
    input wire logic [15:0] high_limit,
    output logic low_active,
    output logic high_active
);
    logic low_r, low_nxt, high_r, high_nxt;
    logic [12:0] hi_release, lo_release;

    // ------------------------------------------------------------
    // hysteresis comparator
    // ------------------------------------------------------------
    always_comb begin
        hi_release = {1'b0, high_limit[11:0]} - {9'h000, high_limit[15:12]};
        lo_release = {1'b0, low_limit[11:0]} + {9'h000, low_limit[15:12]};
        low_nxt = low_r;
        high_nxt = high_r;
        if (sample_valid) begin
            if ({1'b0, sample} > {1'b0, high_limit[11:0]}) begin
                high_nxt = 1'b1;
            // a margin above the limit leaves no release point at all
            end else if (!hi_release[12] && {1'b0, sample} < hi_release) begin
                high_nxt = 1'b0;
            end
            if ({1'b0, sample} < {1'b0, low_limit[11:0]}) begin
                low_nxt = 1'b1;
            end else if ({1'b0, sample} > lo_release) begin
                low_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_r <= 1'b0;
            high_r <= 1'b0;
        end else begin
            low_r <= low_nxt;
            high_r <= high_nxt;
        end
    end

    assign low_active = low_r;
    assign high_active = high_r;
endmodule
`default_nettype wire

/* File: core/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_r, s2_r;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule
`default_nettype wire

/* File: tb/range_alarm_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module range_alarm_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic conv_valid,
    input wire logic [2:0] conv_range,
    input wire logic alarm_or_powerdown_pin,
    input wire logic alarm_or_powerdown_oe,
    input wire logic powerdown_req
);
    // --------
    // page shadow, so page 0 checks skip page 1 reads
    // --------
    logic page_r;
    logic page_nxt;
    always_comb begin
        page_nxt = page_r;
        if (reg_wr && reg_addr == alarm_regs_pkg::bank_select_addr) begin
            page_nxt = reg_wdata[0];
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= 1'b0;
        end else begin
            page_r <= page_nxt;
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_pin_needs_oe: assert property (
        alarm_or_powerdown_pin |-> alarm_or_powerdown_oe)
        else $error("pin driven while not alarm output");
    chk_pd_quiet: assert property (
        alarm_or_powerdown_oe |-> !powerdown_req)
        else $error("power-down request while alarm output");
    chk_range_legal: assert property (
        conv_range inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
        else $error("reserved range code applied");
    chk_range_hold: assert property (
        !conv_valid |=> $stable(conv_range))
        else $error("range changed without conversion");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr == 7'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_flag_pad: assert property (
        reg_rd && !page_r && reg_addr == alarm_regs_pkg::temp_flags_addr
        |=> reg_rdata[3:0] == 4'h0)
        else $error("temperature flag low nibble not zero");
    chk_range_pad: assert property (
        reg_rd && !page_r && reg_addr inside {[7'h10:7'h13]}
        |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("range pad bits set");
    chk_page_echo: assert property (
        reg_rd && reg_addr == alarm_regs_pkg::bank_select_addr
        |=> reg_rdata == {7'h00, page_r})
        else $error("page register readback wrong");
    cover property (reg_rd && page_r);
    cover property ($rose(alarm_or_powerdown_pin));
    cover property (conv_valid && !alarm_or_powerdown_oe);
endmodule
bind adc_range_alarm_registers range_alarm_checker chk_u (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_valid(conv_valid), .conv_range(conv_range),
    .alarm_or_powerdown_pin(alarm_or_powerdown_pin),
    .alarm_or_powerdown_oe(alarm_or_powerdown_oe),
    .powerdown_req(powerdown_req)
);
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // --------
    // one-cycle strobes, entered and left just after an edge
    // --------
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        // released data flips so stale values never match by luck
        reg_wdata = ~d;
        // one idle edge keeps each strobe a single clean pulse
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        // read data stands from the edge after the strobe
        @(posedge mclk);
        d = reg_rdata;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_adc_range_alarm_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module test_adc_range_alarm_registers;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, conv_temp, conv_valid, pd_pin_in, pin, oe, pd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [2:0] conv_chan, conv_range;
    logic [11:0] conv_data;
    int miscompares = 0;
    int checked = 0;
    always #2.5 mclk = ~mclk;
    host_model host_u (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    adc_range_alarm_registers dut_u (.mclk(mclk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_valid(conv_valid), .conv_temp(conv_temp),
        .conv_chan(conv_chan), .conv_data(conv_data),
        .conv_range(conv_range), .pd_pin_in(pd_pin_in),
        .alarm_or_powerdown_pin(pin), .alarm_or_powerdown_oe(oe),
        .powerdown_req(pd));
    // --------
    // helpers
    // --------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host_u.rd(a, d);
        check(d, exp);
    endtask
    task automatic conv(input logic t, input logic [2:0] c,
                        input logic [11:0] v);
        conv_temp = t;
        conv_chan = c;
        conv_data = v;
        conv_valid = 1'b1;
        @(posedge mclk);
        #1;
        conv_valid = 1'b0;
        conv_data = ~v;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // --------
    // scenarios
    // --------
    task automatic test_ranges();
        logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
        logic [7:0] b;
        rd_chk(7'h7f, 8'h00);
        rd_chk(7'h10, 8'h11);
        rd_chk(7'h30, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b = {1'b0, codes[i], 1'b0, codes[4-i]};
            host_u.wr(7'h10 + 7'(i), b);
            rd_chk(7'h10 + 7'(i), b);
        end
        for (int c = 0; c < 8; c++) begin
            conv(1'b0, 3'(c), 12'h000);
            b = {5'h00, c[0] ? codes[4-c/2] : codes[c/2]};
            check({5'h00, conv_range}, b);
        end
    endtask
    task automatic test_limits();
        logic [7:0] v [4] = '{8'h50, 8'h00, 8'h01, 8'h00};
        host_u.wr(7'h7f, 8'h01);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(7'(i), v[i]);
            rd_chk(7'(i), v[i]);
        end
        host_u.wr(7'h06, 8'h28);
        host_u.wr(7'h07, 8'h00);
        host_u.wr(7'h1a, 8'h04);
        host_u.wr(7'h1b, 8'h00);
        rd_chk(7'h06, 8'h28);
        rd_chk(7'h7f, 8'h01);
        host_u.wr(7'h7f, 8'h00);
        rd_chk(7'h10, 8'h16);
    endtask
    task automatic test_alarms();
        conv(1'b0, 3'h0, 12'h801);
        rd_chk(7'h22, 8'h40);
        check({7'h00, pin}, 8'h01);
        rd_chk(7'h21, 8'h40);
        conv(1'b0, 3'h0, 12'h7ff);
        rd_chk(7'h22, 8'h40);
        conv(1'b0, 3'h0, 12'h7fd);
        rd_chk(7'h22, 8'h00);
        rd_chk(7'h21, 8'h40);
        rd_chk(7'h21, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        check({7'h00, pin}, 8'h00);
        conv(1'b1, 3'h0, 12'h200);
        rd_chk(7'h20, 8'h50);
        conv(1'b1, 3'h0, 12'h000);
        rd_chk(7'h20, 8'h40);
        rd_chk(7'h20, 8'h00);
        conv(1'b0, 3'h5, 12'h401);
        rd_chk(7'h24, 8'h10);
        conv(1'b0, 3'h5, 12'h000);
        rd_chk(7'h24, 8'h00);
        rd_chk(7'h23, 8'h10);
        rd_chk(7'h23, 8'h00);
    endtask
    task automatic test_pin_mode();
        host_u.wr(7'h06, 8'h08);
        pd_pin_in = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check({6'h00, oe, pd}, 8'h01);
        pd_pin_in = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        host_u.wr(7'h06, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        check({6'h00, oe, pd}, 8'h02);
    endtask
    task automatic test_reset();
        host_u.wr(7'h10, 8'h25);
        host_u.wr(7'h7f, 8'h01);
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        rd_chk(7'h7f, 8'h00);
        rd_chk(7'h10, 8'h11);
        check({6'h00, oe, pd}, 8'h02);
    endtask
    // a full run is well under 1000 cycles
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end
    initial begin
        conv_valid = 1'b0;
        conv_temp = 1'b0;
        conv_chan = 3'h0;
        conv_data = 12'h000;
        pd_pin_in = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        test_ranges();
        test_limits();
        test_alarms();
        test_pin_mode();
        test_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
